// ==== design/sss_params.svh ====
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH

// Clock and timebase
`define SSS_CLK_NS 40
`define SSS_TICK_NS 1000

// Data widths
`define SSS_VAL_W 16
`define SSS_TIME_W 24
`define SSS_ADDR_W 12

// Timing limits, in their own units
`define SSS_DC_MARGIN_US 300
`define SSS_DC_MIN_PERIOD_MS 10
`define SSS_TRIG_MIN_PERIOD_US 200
`define SSS_US_PER_MS 1000

// Register byte offsets
`define SSS_OFF_CTRL 6'h00
`define SSS_OFF_BIAS 6'h04
`define SSS_OFF_FIRST 6'h08
`define SSS_OFF_LAST 6'h0C
`define SSS_OFF_STEP 6'h10
`define SSS_OFF_PERIOD 6'h14
`define SSS_OFF_MDELAY 6'h18
`define SSS_OFF_SDELAY 6'h1C
`define SSS_OFF_HOLD 6'h20
`define SSS_OFF_TRGDLY 6'h24
`define SSS_OFF_INTEG 6'h28
`define SSS_OFF_CONV 6'h2C
`define SSS_OFF_STATUS 6'h30
`define SSS_OFF_IRQ_STAT 6'h34
`define SSS_OFF_IRQ_MASK 6'h38
`define SSS_OFF_SRCVAL 6'h3C

// Control register fields
`define SSS_CB_START 0
`define SSS_CB_STOP 1
`define SSS_CB_SWEEP 2
`define SSS_CB_TRIG 3
`define SSS_CB_REV 4
`define SSS_CB_EOS 5
`define SSS_CB_OST_LO 6
`define SSS_CB_OST_HI 7

// Status register fields
`define SSS_SB_DIR 5
`define SSS_SB_HELD 6
`define SSS_SB_ERR_LO 8

// Interrupt event bits
`define SSS_IRQ_STEP 0
`define SSS_IRQ_MEAS 1
`define SSS_IRQ_DONE 2
`define SSS_IRQ_ERR 3
`define SSS_IRQ_DROP 4
`define SSS_IRQ_W 5

// Timing check error bits
`define SSS_ERR_DCMARGIN 0
`define SSS_ERR_DCMIN 1
`define SSS_ERR_SDLY 2
`define SSS_ERR_TRGMIN 3
`define SSS_ERR_SUM 4
`define SSS_ERR_W 5

// Reset values
`define SSS_RST_PERIOD 10000
`define SSS_RST_CTRL 8'h00

`endif

// ==== design/sss_pkg.sv ====
package sss_pkg;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_HOLD = 5'h02,
        ST_MDLY = 5'h04,
        ST_MEAS = 5'h08,
        ST_WAIT = 5'h10
    } sss_state_t;

    // Output status of the source
    typedef enum logic [1:0] {
        OS_STANDBY = 2'h0,
        OS_OPERATE = 2'h1,
        OS_SUSPEND = 2'h2
    } sss_ostat_t;

endpackage

// ==== design/sss_interval.sv ====
`timescale 1ns/1ps
`include "sss_params.svh"

module sss_interval #(
    parameter int W = `SSS_TIME_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic tick,
    input wire logic load,
    input wire logic clear,
    input wire logic [W-1:0] value,
    output logic expired
);
    logic [W-1:0] cnt_reg;
    logic active_reg;

    if (W < 2) begin : g_chk
        $error("sss_interval: width too small");
    end

    // Load wins over counting; clear stops the interval
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_reg <= '0;
            active_reg <= 1'b0;
        end else if (load) begin
            cnt_reg <= value;
            active_reg <= 1'b1;
        end else if (clear) begin
            active_reg <= 1'b0;
        end else if (tick && active_reg && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // Stays high until reloaded or cleared
    assign expired = active_reg && (cnt_reg == '0);
endmodule

// ==== design/sss_top.sv ====
`timescale 1ns/1ps
`include "sss_params.svh"

// Summary of operation
// R01 - Bias before sweep, first value at start
// R02 - Sweep: first step waits out hold time
// R03 - Triggers ignored until trigger delay elapses
// R04 - Automatic sampling steps every period
// R05 - Triggered sampling steps only on triggers
// R06 - Reverse bit picks one-way or round
// R07 - Round sweep steps back to first value
// R08 - Timing errors reported in operate or suspend
// R09 - DC: measure delay plus 300us below period
// R10 - DC: period at least 10 ms, forced on switching into DC, only flagged if written lower in DC
// R11 - Back to sweep restores period unless rewritten
// R12 - Sweep: source delay not above measure delay
// R13 - Sweep triggered: period at least 200us
// R14 - Delay, integration, conversion sum below period; checked in DC and auto sweep only, not in triggered sweep
// R15 - Software sets measure delay above settling
// R16 - Triggers during measurement are discarded
// R17 - No measurement in standby or suspend
// R18 - One-cycle sync and completion pulses
// R19 - Intervals counted in one timebase, loaded
module sss_top #(
    parameter int VW = `SSS_VAL_W,
    parameter int TW = `SSS_TIME_W
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`SSS_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TRIGGER_IN,
    output logic [VW-1:0] SOURCE_VALUE,
    output logic SYNC_OUT,
    output logic COMPLETE_OUT,
    output logic IRQ,
    output sss_pkg::sss_state_t SEQ_STATE
);
    import sss_pkg::*;

    localparam int TICK_CYC = (`SSS_TICK_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS;
    localparam logic [TW+1:0] DC_MARGIN = (TW+2)'(`SSS_DC_MARGIN_US * `SSS_TICK_NS / 1000);
    localparam logic [TW-1:0] DC_MIN =
        TW'(`SSS_DC_MIN_PERIOD_MS * `SSS_US_PER_MS * `SSS_TICK_NS / 1000);
    localparam logic [TW-1:0] TRG_MIN = TW'(`SSS_TRIG_MIN_PERIOD_US * `SSS_TICK_NS / 1000);

    if (VW < 2 || VW > 32 || TW < 15 || TW > 30) begin : g_chk
        $error("sss_top: unsupported width parameter");
    end

    logic pready_reg, pslverr_reg, irq_reg, sync_reg, cmpl_reg, trig_q_reg;
    logic [31:0] prdata_reg, rd_mux;
    logic mode_reg, samp_reg, rev_reg, eos_reg, dir_down_reg, held_reg, dc_wr_reg;
    logic [1:0] ostat_reg;
    logic [VW-1:0] bias_reg, first_reg, last_reg, step_reg, cur_reg, src_reg;
    logic [TW-1:0] period_reg, saved_reg, mdly_reg, sdly_reg, hold_reg, trgdly_reg;
    logic [TW-1:0] integ_reg, conv_reg;
    logic [`SSS_ERR_W-1:0] err_reg, errs;
    logic [`SSS_IRQ_W-1:0] irq_stat_reg, irq_mask_reg, ev;
    logic [7:0] tick_cnt_reg;
    sss_state_t state_reg;

    // Bus decode
    logic setup, hit, wr_acc, wr_ctrl, new_mode, start_cmd, stop_cmd;
    assign setup = PSEL && !PENABLE;
    assign hit = (PADDR[`SSS_ADDR_W-1:6] == '0) && (PADDR[1:0] == 2'h0);
    assign wr_acc = PSEL && PENABLE && PWRITE && pready_reg && hit;
    assign wr_ctrl = wr_acc && PADDR[5:0] == `SSS_OFF_CTRL;
    assign new_mode = PWDATA[`SSS_CB_SWEEP];
    assign start_cmd = wr_ctrl && PWDATA[`SSS_CB_START];
    assign stop_cmd = wr_ctrl && PWDATA[`SSS_CB_STOP];

    // Sequencer control terms
    logic tick, operate, trig_edge, trig_acc, drop, step_go, start_go, abort, meas_done, finish;
    logic hold_exp, trg_exp, sdly_exp, mdly_exp, meas_exp, per_exp;
    logic [VW-1:0] nxt_val;
    logic nxt_dir, step_load;
    logic [VW:0] up_sum;
    logic [TW:0] meas_len;
    assign tick = (tick_cnt_reg == 8'(TICK_CYC - 1));
    assign operate = (ostat_reg == OS_OPERATE);
    assign trig_edge = TRIGGER_IN && !trig_q_reg;
    assign trig_acc = trig_edge && trg_exp; // [R03]
    assign drop = trig_edge && samp_reg && (state_reg == ST_MDLY || state_reg == ST_MEAS); // [R16]
    assign start_go = start_cmd && operate && state_reg == ST_IDLE; // [R17]
    assign abort = state_reg != ST_IDLE && (stop_cmd || !operate); // [R17]
    assign step_go = !abort && ((state_reg == ST_HOLD && hold_exp) // [R02]
        || (state_reg == ST_WAIT && (samp_reg ? trig_acc : per_exp))); // [R04] [R05]
    assign meas_done = !abort && state_reg == ST_MEAS && meas_exp;
    assign step_load = step_go || (start_go && !mode_reg); // DC start is a step too
    assign up_sum = {1'b0, cur_reg} + {1'b0, step_reg};
    assign meas_len = {1'b0, integ_reg} + {1'b0, conv_reg};

    // Next sweep point; one-way ends at last, round turns back there
    always_comb begin
        nxt_val = cur_reg;
        nxt_dir = dir_down_reg;
        finish = 1'b0;
        if (!mode_reg) begin
            nxt_val = bias_reg;
        end else if (!dir_down_reg) begin
            if (cur_reg >= last_reg) begin
                if (rev_reg) begin // [R06] [R07]
                    nxt_dir = 1'b1;
                    nxt_val = (last_reg - first_reg > step_reg) ? last_reg - step_reg : first_reg;
                end else begin
                    finish = 1'b1;
                end
            end else begin
                nxt_val = (up_sum >= {1'b0, last_reg}) ? last_reg : up_sum[VW-1:0];
            end
        end else if (cur_reg <= first_reg) begin
            finish = 1'b1;
        end else begin
            nxt_val = (cur_reg - first_reg > step_reg) ? cur_reg - step_reg : first_reg; // [R07]
        end
    end

    // Timebase prescaler
    always_ff @(posedge CLOCK) begin
        if (RST || tick) begin
            tick_cnt_reg <= 8'h00;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 8'h01;
        end
    end

    // Interval timers, each loaded at its own starting event
    sss_interval #(.W(TW)) u_hold (.clock(CLOCK), .rst(RST), .tick(tick), .load(start_go),
        .clear(abort), .value(hold_reg), .expired(hold_exp)); // [R19]
    sss_interval #(.W(TW)) u_trg (.clock(CLOCK), .rst(RST), .tick(tick), .load(start_go),
        .clear(abort), .value(trgdly_reg), .expired(trg_exp));
    sss_interval #(.W(TW)) u_sdly (.clock(CLOCK), .rst(RST), .tick(tick), .load(step_load),
        .clear(abort), .value(sdly_reg), .expired(sdly_exp));
    sss_interval #(.W(TW)) u_mdly (.clock(CLOCK), .rst(RST), .tick(tick), .load(step_load),
        .clear(abort), .value(mdly_reg), .expired(mdly_exp));
    sss_interval #(.W(TW)) u_per (.clock(CLOCK), .rst(RST), .tick(tick), .load(step_load),
        .clear(abort), .value(period_reg), .expired(per_exp));
    sss_interval #(.W(TW+1)) u_meas (.clock(CLOCK), .rst(RST), .tick(tick),
        .load(state_reg == ST_MDLY && mdly_exp), .clear(abort), .value(meas_len),
        .expired(meas_exp));

    // Sequencer state
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: if (start_go) state_reg <= mode_reg ? ST_HOLD : ST_MDLY;
                ST_HOLD: if (abort) state_reg <= ST_IDLE; else if (step_go) state_reg <= ST_MDLY;
                ST_MDLY: if (abort) state_reg <= ST_IDLE; else if (mdly_exp) state_reg <= ST_MEAS;
                ST_MEAS: if (abort || (meas_done && finish)) state_reg <= ST_IDLE;
                    else if (meas_done) state_reg <= ST_WAIT;
                ST_WAIT: if (abort) state_reg <= ST_IDLE; else if (step_go) state_reg <= ST_MDLY;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Sweep point, direction and source output
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cur_reg <= '0;
            src_reg <= '0;
            dir_down_reg <= 1'b0;
            held_reg <= 1'b0;
        end else if (start_go) begin
            cur_reg <= mode_reg ? first_reg : bias_reg;
            src_reg <= mode_reg ? first_reg : bias_reg; // [R01]
            dir_down_reg <= 1'b0;
            held_reg <= 1'b0;
        end else if (state_reg == ST_IDLE) begin
            if (!held_reg) src_reg <= bias_reg; // [R01]
        end else if (abort) begin
            src_reg <= bias_reg;
        end else if (meas_done) begin
            cur_reg <= nxt_val;
            dir_down_reg <= nxt_dir;
            held_reg <= finish && eos_reg;
            if (finish && !eos_reg) src_reg <= bias_reg;
        end else if ((state_reg == ST_MDLY || state_reg == ST_MEAS) && sdly_exp) begin
            src_reg <= cur_reg;
        end
    end

    // Step start and completion pulses
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sync_reg <= 1'b0;
            cmpl_reg <= 1'b0;
            trig_q_reg <= 1'b0;
        end else begin
            sync_reg <= step_load; // [R18]
            cmpl_reg <= meas_done; // [R18]
            trig_q_reg <= TRIGGER_IN;
        end
    end

    // Control and setting registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            {eos_reg, rev_reg, samp_reg, mode_reg} <= 4'h0;
            ostat_reg <= OS_STANDBY;
            {bias_reg, first_reg, last_reg, step_reg} <= '0;
            {mdly_reg, sdly_reg, hold_reg, trgdly_reg, integ_reg, conv_reg} <= '0;
        end else if (wr_acc) begin
            case (PADDR[5:0])
                `SSS_OFF_CTRL: begin
                    mode_reg <= PWDATA[`SSS_CB_SWEEP];
                    samp_reg <= PWDATA[`SSS_CB_TRIG];
                    rev_reg <= PWDATA[`SSS_CB_REV]; // [R06]
                    eos_reg <= PWDATA[`SSS_CB_EOS];
                    ostat_reg <= PWDATA[`SSS_CB_OST_HI:`SSS_CB_OST_LO];
                end
                `SSS_OFF_BIAS: bias_reg <= PWDATA[VW-1:0];
                `SSS_OFF_FIRST: first_reg <= PWDATA[VW-1:0];
                `SSS_OFF_LAST: last_reg <= PWDATA[VW-1:0];
                `SSS_OFF_STEP: step_reg <= PWDATA[VW-1:0];
                `SSS_OFF_MDELAY: mdly_reg <= PWDATA[TW-1:0];
                `SSS_OFF_SDELAY: sdly_reg <= PWDATA[TW-1:0];
                `SSS_OFF_HOLD: hold_reg <= PWDATA[TW-1:0];
                `SSS_OFF_TRGDLY: trgdly_reg <= PWDATA[TW-1:0];
                `SSS_OFF_INTEG: integ_reg <= PWDATA[TW-1:0];
                `SSS_OFF_CONV: conv_reg <= PWDATA[TW-1:0];
                default: ;
            endcase
        end
    end

    // Period with DC floor and sweep restore
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            period_reg <= TW'(`SSS_RST_PERIOD);
            saved_reg <= TW'(`SSS_RST_PERIOD);
            dc_wr_reg <= 1'b0;
        end else if (wr_ctrl && mode_reg && !new_mode) begin
            saved_reg <= period_reg;
            dc_wr_reg <= 1'b0;
            if (period_reg < DC_MIN) period_reg <= DC_MIN; // [R10]
        end else if (wr_ctrl && !mode_reg && new_mode) begin
            if (!dc_wr_reg) period_reg <= saved_reg; // [R11]
        end else if (wr_acc && PADDR[5:0] == `SSS_OFF_PERIOD) begin
            period_reg <= PWDATA[TW-1:0];
            if (!mode_reg) dc_wr_reg <= 1'b1; // [R11]
        end
    end

    // Timing parameter checks
    always_comb begin
        errs = '0;
        errs[`SSS_ERR_DCMARGIN] = !mode_reg
            && ({2'b0, mdly_reg} + DC_MARGIN >= {2'b0, period_reg}); // [R09]
        errs[`SSS_ERR_DCMIN] = !mode_reg && period_reg < DC_MIN; // [R10]
        errs[`SSS_ERR_SDLY] = mode_reg && sdly_reg > mdly_reg; // [R12]
        errs[`SSS_ERR_TRGMIN] = mode_reg && samp_reg && period_reg < TRG_MIN; // [R13]
        errs[`SSS_ERR_SUM] = (!mode_reg || !samp_reg)
            && ({2'b0, mdly_reg} + {1'b0, meas_len} >= {2'b0, period_reg}); // [R14]
    end

    // Error flags shown only in operate or suspend
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            err_reg <= '0;
        end else begin
            err_reg <= (ostat_reg == OS_OPERATE || ostat_reg == OS_SUSPEND) ? errs : '0; // [R08]
        end
    end

    // Sticky events, write one to clear; a new event wins
    assign ev = {drop, (|(errs & ~err_reg)) && (operate || ostat_reg == OS_SUSPEND),
                 meas_done && finish, meas_done, step_go};
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~((wr_acc && PADDR[5:0] == `SSS_OFF_IRQ_STAT)
                ? PWDATA[`SSS_IRQ_W-1:0] : '0)) | ev;
            if (wr_acc && PADDR[5:0] == `SSS_OFF_IRQ_MASK) irq_mask_reg <= PWDATA[`SSS_IRQ_W-1:0];
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Read data select
    always_comb begin
        rd_mux = 32'h00000000;
        case (PADDR[5:0])
            `SSS_OFF_CTRL: rd_mux = 32'({ostat_reg, eos_reg, rev_reg, samp_reg, mode_reg, 2'b00});
            `SSS_OFF_BIAS: rd_mux = 32'(bias_reg);
            `SSS_OFF_FIRST: rd_mux = 32'(first_reg);
            `SSS_OFF_LAST: rd_mux = 32'(last_reg);
            `SSS_OFF_STEP: rd_mux = 32'(step_reg);
            `SSS_OFF_PERIOD: rd_mux = 32'(period_reg);
            `SSS_OFF_MDELAY: rd_mux = 32'(mdly_reg);
            `SSS_OFF_SDELAY: rd_mux = 32'(sdly_reg);
            `SSS_OFF_HOLD: rd_mux = 32'(hold_reg);
            `SSS_OFF_TRGDLY: rd_mux = 32'(trgdly_reg);
            `SSS_OFF_INTEG: rd_mux = 32'(integ_reg);
            `SSS_OFF_CONV: rd_mux = 32'(conv_reg);
            `SSS_OFF_STATUS: begin
                rd_mux[4:0] = state_reg;
                rd_mux[`SSS_SB_DIR] = dir_down_reg;
                rd_mux[`SSS_SB_HELD] = held_reg;
                rd_mux[`SSS_SB_ERR_LO +: `SSS_ERR_W] = err_reg;
            end
            `SSS_OFF_IRQ_STAT: rd_mux = 32'(irq_stat_reg);
            `SSS_OFF_IRQ_MASK: rd_mux = 32'(irq_mask_reg);
            `SSS_OFF_SRCVAL: rd_mux = 32'(src_reg);
            default: rd_mux = 32'h00000000;
        endcase
    end

    // APB answer: one wait-free access cycle, data and error caught at setup
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !hit;
            if (setup) prdata_reg <= (hit && !PWRITE) ? rd_mux : 32'h00000000;
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign IRQ = irq_reg;
    assign SOURCE_VALUE = src_reg;
    assign SYNC_OUT = sync_reg;
    assign COMPLETE_OUT = cmpl_reg;
    assign SEQ_STATE = state_reg;

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    idle_bias_a: assert property (state_reg == ST_IDLE && !held_reg && !start_go // [R01]
        |=> src_reg == $past(bias_reg)) else $error("idle source is not bias");
    start_first_a: assert property (start_go && mode_reg // [R01]
        |=> src_reg == $past(first_reg) && state_reg == ST_HOLD) else $error("start value wrong");
    hold_wait_a: assert property (state_reg == ST_HOLD && !hold_exp // [R02]
        |=> state_reg inside {ST_HOLD, ST_IDLE}) else $error("step before hold time");
    trig_early_a: assert property (state_reg == ST_WAIT && samp_reg && !trg_exp && !per_exp // [R03]
        |=> !sync_reg) else $error("trigger taken before trigger delay");
    auto_step_a: assert property (state_reg == ST_WAIT && !samp_reg && per_exp && !abort // [R04]
        |=> sync_reg && state_reg == ST_MDLY) else $error("auto step missed period");
    trig_only_a: assert property (state_reg == ST_WAIT && samp_reg && !trig_acc // [R05]
        |=> !sync_reg) else $error("triggered step without trigger");
    reverse_a: assert property ($rose(dir_down_reg) |-> $past(rev_reg)) // [R06]
        else $error("turned back without reverse");
    dc_force_a: assert property (wr_ctrl && mode_reg && !new_mode && period_reg < DC_MIN // [R10]
        |=> period_reg == DC_MIN) else $error("dc period not forced");
    src_err_a: assert property (mode_reg && sdly_reg > mdly_reg && operate // [R12]
        && $stable(ostat_reg) |=> err_reg[`SSS_ERR_SDLY]) else $error("source delay error missed");
    drop_a: assert property (drop |=> irq_stat_reg[`SSS_IRQ_DROP] && !sync_reg) // [R16]
        else $error("busy trigger not discarded");
    standby_a: assert property (state_reg != ST_IDLE && !operate // [R17]
        |=> state_reg == ST_IDLE) else $error("measuring while not operating");
    pulse_a: assert property (sync_reg |=> !sync_reg ##1 !cmpl_reg || state_reg == ST_MEAS) // [R18]
        else $error("sync pulse too long");

    round_done_c: cover property (rev_reg && dir_down_reg && meas_done && finish);
    trig_step_c: cover property (state_reg == ST_WAIT && samp_reg && trig_acc);
    dc_run_c: cover property (!mode_reg && state_reg == ST_WAIT && per_exp);
endmodule

// ==== test/sss_trig_src.sv ====
`timescale 1ns/1ps

// Trigger source and sync/completion receiver at the far side
module sss_trig_src (
    input wire logic clock,
    input wire logic rst,
    input wire logic fire,
    input wire logic sync,
    input wire logic complete,
    output logic trigger,
    output int n_sync,
    output int n_done,
    output int gap
);
    logic [1:0] hold_reg;
    int since_reg;

    // Trigger is a short high pulse, low when idle
    always_ff @(posedge clock) begin
        if (rst || (hold_reg == 2'h0 && !fire)) begin
            trigger <= 1'b0;
            hold_reg <= 2'h0;
        end else if (fire) begin
            trigger <= 1'b1;
            hold_reg <= 2'h2;
        end else begin
            hold_reg <= hold_reg - 2'h1;
        end
    end

    // Count pulses and cycles between step starts
    always_ff @(posedge clock) begin
        if (rst) begin
            n_sync <= 0;
            n_done <= 0;
            gap <= 0;
            since_reg <= 0;
        end else begin
            since_reg <= sync ? 1 : since_reg + 1;
            if (sync) begin
                n_sync <= n_sync + 1;
                gap <= since_reg;
            end
            if (complete) begin
                n_done <= n_done + 1;
            end
        end
    end
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
`include "sss_params.svh"

module tb;
    import sss_pkg::*;
    logic CLOCK, RST, PSEL, PENABLE, PWRITE, fire, PREADY, PSLVERR, err;
    logic TRIGGER_IN, SYNC_OUT, COMPLETE_OUT, IRQ;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [15:0] SOURCE_VALUE, bias;
    sss_state_t SEQ_STATE;
    int n_errors, comparisons, cyc, n_sync, n_done, gap, n0;
    logic [31:0] x;

    sss_top uut (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .TRIGGER_IN(TRIGGER_IN), .SOURCE_VALUE(SOURCE_VALUE), .SYNC_OUT(SYNC_OUT),
        .COMPLETE_OUT(COMPLETE_OUT), .IRQ(IRQ), .SEQ_STATE(SEQ_STATE));
    sss_trig_src far (.clock(CLOCK), .rst(RST), .fire(fire), .sync(SYNC_OUT),
        .complete(COMPLETE_OUT), .trigger(TRIGGER_IN), .n_sync(n_sync), .n_done(n_done),
        .gap(gap));

    // Repeatable xorshift stimulus
    function automatic logic [31:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        @(posedge CLOCK);
        while (PREADY !== 1'b1) begin
            @(posedge CLOCK);
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic wait_st(input sss_state_t s);
        int k;
        k = 0;
        while (SEQ_STATE !== s && k < 20000) begin
            k++;
            @(posedge CLOCK);
        end
        chk("state", s, SEQ_STATE);
    endtask

    task automatic pulse();
        @(posedge CLOCK);
        fire <= 1'b1;
        @(posedge CLOCK);
        fire <= 1'b0;
    endtask

    // Auto sweep with random first value and step; checks first point, count and end value
    task automatic sweep(input logic [31:0] ctl);
        logic [15:0] f, s, e;
        int n;
        f = 16'(rnd() % 16);
        s = 16'(rnd() % 4 + 1);
        n = ctl[4] ? 5 : 3;
        e = ctl[5] ? (ctl[4] ? f : f + 16'h2 * s) : bias;
        apb(1'b1, `SSS_OFF_FIRST, {16'h0, f});
        apb(1'b1, `SSS_OFF_LAST, {16'h0, f + 16'h2 * s});
        apb(1'b1, `SSS_OFF_STEP, {16'h0, s});
        apb(1'b1, `SSS_OFF_CTRL, ctl);
        n0 = n_sync;
        chk("bias", bias, SOURCE_VALUE);
        apb(1'b1, `SSS_OFF_CTRL, ctl | 32'h1);
        @(posedge CLOCK);
        chk("held", ST_HOLD, SEQ_STATE);
        chk("first", f, SOURCE_VALUE);
        chk("no sync in hold", n0, n_sync);
        wait_st(ST_IDLE);
        @(posedge CLOCK);
        chk("steps", n0 + n, n_sync);
        chk("done", n_sync, n_done);
        chk("gap ok", 1, gap >= 19 * 25 && gap <= 20 * 25 + 4);
        chk("end value", e, SOURCE_VALUE);
    endtask

    // Clock and cycle ceiling
    initial begin
        CLOCK = 1'b0;
        forever #20 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic final_report();
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {RST, PSEL, PENABLE, PWRITE, fire, PADDR, PWDATA} = {1'b1, 48'h0};
        {n_errors, comparisons, cyc} = 0;
        x = 32'hF8D1AF9C;
        bias = 16'(rnd() % 256);
        repeat (20) @(posedge CLOCK);
        RST <= 1'b0;
        rdc("period reset", `SSS_OFF_PERIOD, `SSS_RST_PERIOD);
        chk("idle", ST_IDLE, SEQ_STATE);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped", 1, err);
        // Step timing in ticks; source delay first set past measure delay
        apb(1'b1, `SSS_OFF_BIAS, {16'h0, bias});
        apb(1'b1, `SSS_OFF_PERIOD, 32'd20);
        apb(1'b1, `SSS_OFF_MDELAY, 32'd2);
        apb(1'b1, `SSS_OFF_HOLD, 32'd2);
        apb(1'b1, `SSS_OFF_INTEG, 32'd2);
        apb(1'b1, `SSS_OFF_CONV, 32'd1);
        apb(1'b1, `SSS_OFF_SDELAY, 32'd3);
        apb(1'b1, `SSS_OFF_CTRL, 32'h05);
        @(posedge CLOCK);
        chk("standby start", ST_IDLE, SEQ_STATE);
        rdc("standby errs", `SSS_OFF_STATUS, {19'h0, 5'h0, 3'h0, 5'(ST_IDLE)});
        apb(1'b1, `SSS_OFF_CTRL, 32'h44);
        apb(1'b0, `SSS_OFF_STATUS, 32'h0);
        chk("sdelay err", 1, rd[10]);
        apb(1'b1, `SSS_OFF_SDELAY, 32'd1);
        apb(1'b1, `SSS_OFF_INTEG, 32'd30);
        apb(1'b0, `SSS_OFF_STATUS, 32'h0);
        chk("sum err", 2'b10, {rd[12], rd[10]});
        apb(1'b1, `SSS_OFF_INTEG, 32'd2);
        sweep(32'h44);
        sweep(32'h54);
        sweep(32'h74);
        // Interrupt: done flag masked, then unmasked, then cleared
        chk("masked irq", 0, IRQ);
        apb(1'b1, `SSS_OFF_IRQ_MASK, 32'h4);
        repeat (3) @(posedge CLOCK);
        chk("irq up", 1, IRQ);
        apb(1'b1, `SSS_OFF_IRQ_STAT, 32'h1F);
        repeat (3) @(posedge CLOCK);
        chk("irq clear", 0, IRQ);
        // Triggered sampling with trigger delay
        apb(1'b1, `SSS_OFF_PERIOD, 32'd100);
        apb(1'b1, `SSS_OFF_TRGDLY, 32'd60);
        apb(1'b1, `SSS_OFF_CTRL, 32'h4C);
        apb(1'b0, `SSS_OFF_STATUS, 32'h0);
        chk("trig period err", 1, rd[11]);
        apb(1'b1, `SSS_OFF_PERIOD, 32'd200);
        apb(1'b1, `SSS_OFF_CTRL, 32'h4D);
        wait_st(ST_WAIT);
        n0 = n_sync;
        pulse();
        repeat (5300) @(posedge CLOCK);
        chk("early trig", n0, n_sync);
        pulse();
        wait_st(ST_MDLY);
        pulse();
        wait_st(ST_WAIT);
        chk("trig step", n0 + 1, n_sync);
        apb(1'b0, `SSS_OFF_IRQ_STAT, 32'h0);
        chk("dropped", 1, rd[4]);
        apb(1'b1, `SSS_OFF_CTRL, 32'h4E);
        wait_st(ST_IDLE);
        // DC period forcing and restore
        apb(1'b1, `SSS_OFF_PERIOD, 32'd50);
        apb(1'b1, `SSS_OFF_CTRL, 32'h40);
        rdc("dc forced", `SSS_OFF_PERIOD, 32'd10000);
        apb(1'b1, `SSS_OFF_MDELAY, 32'd9800);
        apb(1'b0, `SSS_OFF_STATUS, 32'h0);
        chk("dc margin", 1, rd[8]);
        apb(1'b1, `SSS_OFF_CTRL, 32'h44);
        rdc("restored", `SSS_OFF_PERIOD, 32'd50);
        apb(1'b1, `SSS_OFF_CTRL, 32'h40);
        apb(1'b1, `SSS_OFF_PERIOD, 32'd5000);
        apb(1'b0, `SSS_OFF_STATUS, 32'h0);
        chk("dc min", 1, rd[9]);
        apb(1'b1, `SSS_OFF_CTRL, 32'h44);
        rdc("kept", `SSS_OFF_PERIOD, 32'd5000);
        // DC run: start steps at once and measures
        apb(1'b1, `SSS_OFF_MDELAY, 32'd2);
        apb(1'b1, `SSS_OFF_CTRL, 32'h40);
        n0 = n_sync;
        apb(1'b1, `SSS_OFF_CTRL, 32'h41);
        wait_st(ST_WAIT);
        chk("dc step", n0 + 1, n_sync);
        final_report();
    end
endmodule
